// ---- logic/branch_unit.sv ----
// branch target and bit operand unit behind an APB register file
// assumes APB master on clk_sys_i; pc_target_o is picked up by the core on pc_load_o
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "branch_defs.svh"

// Function
// - extended bit ops reach RAM bytes 20H-7FH and every SFR byte.
// - legacy location form limited to RAM 20H-2FH and SFRs ending 0H or 8H.
// - legacy numeric bit address 00H-7FH maps to 20H.0 through 2FH.7.
// - legacy numeric 80H-F8H maps onto bits of SFRs 80H, 88H ... F8H.
// - extended bit ops use location plus position, never a numeric bit address.
// - relative target is next address plus sign-extended 8-bit offset.
// - eleven-bit target replaces only low 11 bits of next address.
// - sixteen-bit target replaces only low 16 bits, keeps upper eight.
// - twentyfour-bit target loads all 24 program counter bits.
// - word register indirect loads 16-bit value, keeps upper eight bits.
// - accumulator plus data pointer sum goes low, upper byte forced FFH.
// - conditional jumps are relative and must stay in current 256-byte block.
// - jump on set bit, on clear bit; jump-and-clear jumps then clears.
// - compare jumps read current flags of both status words.
// - six relations, ordering ones in signed and unsigned variants.
// - compare computes difference unstored, updates carry, ovf, sign, zero; aux on byte compares only.
module branch_unit (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             pc_load_o,
  output logic      [23:0] pc_target_o,
  output logic             branch_taken_o
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  branch_pkg::state_t state_reg;
  logic [5:0]  op_reg;
  logic [23:0] next_pc_reg;
  logic [23:0] operand_reg;
  logic [7:0]  acc_reg;
  logic [15:0] data_pointer_reg;
  logic [12:0] bit_sel_reg;
  logic [4:0]  flags_reg;
  logic [4:0]  flags_next;
  logic [31:0] cmp_reg;
  logic        loc_err_reg;
  logic        block_err_reg;
  logic        bit_val_reg;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire setup_phase = psel_i & ~penable_i;
  wire idle        = (state_reg == branch_pkg::S_IDLE);
  wire wr_take     = psel_i & penable_i & pwrite_i & pready_o & idle;
  wire hit_op      = (paddr_i == `ADDR_OP);
  wire hit_pc      = (paddr_i == `ADDR_NEXT_PC);
  wire hit_operand = (paddr_i == `ADDR_OPERAND);
  wire hit_accdp   = (paddr_i == `ADDR_ACC_DATA_POINTER);
  wire hit_sel     = (paddr_i == `ADDR_BIT_SEL);
  wire hit_flags   = (paddr_i == `ADDR_FLAGS);
  wire hit_cmp     = (paddr_i == `ADDR_CMP);
  wire hit_result  = (paddr_i == `ADDR_RESULT);
  wire hit_any     = hit_op | hit_pc | hit_operand | hit_accdp | hit_sel | hit_flags
                   | hit_cmp | hit_result;
  wire go          = wr_take & hit_op;
  wire [31:0] result_word = {~idle, 3'h0, bit_val_reg, block_err_reg, loc_err_reg,
                             branch_taken_o, pc_target_o};
  wire [31:0] rd_mux =
      hit_op      ? {26'h0, op_reg} :
      hit_pc      ? {8'h00, next_pc_reg} :
      hit_operand ? {8'h00, operand_reg} :
      hit_accdp   ? {8'h00, data_pointer_reg, acc_reg} :
      hit_sel     ? {19'h0, bit_sel_reg} :
      hit_flags   ? {27'h0, flags_reg} :
      hit_cmp     ? cmp_reg :
      hit_result  ? result_word : 32'h0000_0000;

  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= 1'b1;
      pslverr_o <= setup_phase & ~hit_any;
      if (setup_phase) begin
        prdata_o <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // bit operand location
  // ****************************************************************
  wire [1:0] sel_mode  = bit_sel_reg[12:11];
  wire [7:0] sel_loc   = bit_sel_reg[7:0];
  wire [2:0] sel_pos   = bit_sel_reg[10:8];
  wire       in_ram    = (sel_loc >= `LOC_RAM_LO) & (sel_loc <= `LOC_RAM_HI);
  wire       in_ram_lg = (sel_loc >= `LOC_RAM_LO) & (sel_loc <= `LOC_LEGACY_HI);
  wire       sfr_row   = sel_loc[7] & (sel_loc[2:0] == 3'h0);
  // numeric form: low half walks the RAM bytes, high half picks row SFRs
  wire [7:0] num_byte  = sel_loc[7] ? {sel_loc[7:3], 3'h0}
                                    : (`LOC_RAM_LO + {4'h0, sel_loc[6:3]});
  wire       is_num    = (sel_mode == `MODE_LEG_NUM);
  wire [7:0] byte_loc  = is_num ? num_byte : sel_loc;
  wire [2:0] bit_pos   = is_num ? sel_loc[2:0] : sel_pos;
  wire       loc_ok    = (sel_mode == `MODE_EXT_LOC) ? (in_ram | sel_loc[7])
                       : (sel_mode == `MODE_LEG_LOC) ? (in_ram_lg | sfr_row)
                       : is_num;

  // ****************************************************************
  // target arithmetic
  // ****************************************************************
  branch_pkg::op_t op_code;
  assign op_code = branch_pkg::op_t'(op_reg[4:0]);
  wire        wide       = op_reg[`OP_WIDE_BIT];
  wire [23:0] rel_sext   = {{16{operand_reg[7]}}, operand_reg[7:0]};
  wire [23:0] rel_target = next_pc_reg + rel_sext;
  wire [23:0] t_eleven   = {next_pc_reg[23:11], operand_reg[10:0]};
  wire [23:0] t_sixteen  = {next_pc_reg[23:16], operand_reg[15:0]};
  wire [15:0] dp_sum     = data_pointer_reg + {8'h00, acc_reg};
  wire [23:0] t_acc_dp   = {`REGION_CODE, dp_sum};
  wire        is_cond    = (op_code == branch_pkg::OP_JB) | (op_code == branch_pkg::OP_JNB)
                         | (op_code == branch_pkg::OP_JBC)
                         | ((op_reg[4:0] >= `OPC_JE) & (op_reg[4:0] <= `OPC_JUMP_SIGNED_LESSER_OR_SAME));
  wire        block_err  = is_cond & (rel_target[23:8] != next_pc_reg[23:8]);
  wire        is_bit_op  = (op_reg[4:0] >= `OPC_JB) & (op_reg[4:0] <= `OPC_CLRB);

  // ****************************************************************
  // compare and flag conditions
  // ****************************************************************
  wire [15:0] cmp_a   = cmp_reg[15:0];
  wire [15:0] cmp_b   = cmp_reg[31:16];
  wire [16:0] diff16  = {1'b0, cmp_a} - {1'b0, cmp_b};
  wire [8:0]  diff8   = {1'b0, cmp_a[7:0]} - {1'b0, cmp_b[7:0]};
  wire [4:0]  diff4   = {1'b0, cmp_a[3:0]} - {1'b0, cmp_b[3:0]};
  wire        c_carry = wide ? diff16[16] : diff8[8];
  wire        c_sign  = wide ? diff16[15] : diff8[7];
  wire        c_zero  = wide ? (diff16[15:0] == 16'h0000) : (diff8[7:0] == 8'h00);
  wire        c_ovf   = wide ? ((cmp_a[15] ^ cmp_b[15]) & (cmp_a[15] ^ diff16[15]))
                             : ((cmp_a[7] ^ cmp_b[7]) & (cmp_a[7] ^ diff8[7]));
  // aux carry only follows byte compares
  wire        c_aux   = wide ? flags_reg[`FLAG_AUX] : diff4[4];
  wire        f_cy    = flags_reg[`FLAG_CARRY];
  wire        f_z     = flags_reg[`FLAG_ZERO];
  wire        f_lt    = flags_reg[`FLAG_SIGN] ^ flags_reg[`FLAG_OVF];
  logic [7:0] store_rd;
  wire        bit_now = store_rd[bit_pos];

  logic       cond_hit;
  logic [23:0] target_calc;

  always_comb begin
    cond_hit    = 1'b0;
    target_calc = rel_target;
    case (op_code)
      branch_pkg::OP_REL:      cond_hit = 1'b1;
      branch_pkg::OP_ABS11:    begin cond_hit = 1'b1; target_calc = t_eleven; end
      branch_pkg::OP_LONG16,
      branch_pkg::OP_WORD_IND: begin cond_hit = 1'b1; target_calc = t_sixteen; end
      branch_pkg::OP_EXT24:    begin cond_hit = 1'b1; target_calc = operand_reg; end
      branch_pkg::OP_ACC_DATA_POINTER: begin cond_hit = 1'b1; target_calc = t_acc_dp; end
      branch_pkg::OP_JB,
      branch_pkg::OP_JBC:      cond_hit = bit_now & loc_ok;
      branch_pkg::OP_JNB:      cond_hit = ~bit_now & loc_ok;
      branch_pkg::OP_JE:       cond_hit = f_z;
      branch_pkg::OP_JNE:      cond_hit = ~f_z;
      branch_pkg::OP_JG:       cond_hit = ~f_cy & ~f_z;
      branch_pkg::OP_JL:       cond_hit = f_cy;
      branch_pkg::OP_JGE:      cond_hit = ~f_cy;
      branch_pkg::OP_JLE:      cond_hit = f_cy | f_z;
      branch_pkg::OP_JSG:      cond_hit = ~f_z & ~f_lt;
      branch_pkg::OP_JSL:      cond_hit = f_lt;
      branch_pkg::OP_JUMP_SIGNED_GREATER_OR_SAME:     cond_hit = ~f_lt;
      branch_pkg::OP_JUMP_SIGNED_LESSER_OR_SAME:     cond_hit = f_z | f_lt;
      default:                 begin cond_hit = 1'b0; target_calc = next_pc_reg; end
    endcase
  end

  wire taken_calc = cond_hit & ~block_err;

  // ****************************************************************
  // bit store and read-modify-write
  // ****************************************************************
  wire       exec      = (state_reg == branch_pkg::S_EXEC);
  wire       bit_clear = (op_code == branch_pkg::OP_CLRB) | ((op_code == branch_pkg::OP_JBC)
                       & taken_calc);
  wire       bit_set   = (op_code == branch_pkg::OP_SETB);
  wire       store_we  = exec & loc_ok & (bit_clear | bit_set);
  wire [7:0] pos_mask  = 8'h01 << bit_pos;
  wire [7:0] store_wd  = bit_set ? (store_rd | pos_mask) : (store_rd & ~pos_mask);

  bit_byte_store u_store (
    .clk_i     (clk_sys_i),
    .rst_n_i   (rst_sync_reg),
    .addr_i    (byte_loc),
    .wr_en_i   (store_we),
    .wr_data_i (store_wd),
    .rd_data_o (store_rd)
  );

  // ****************************************************************
  // sequencing: fetch the operand byte, then execute
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= branch_pkg::S_IDLE;
    end else begin
      case (state_reg)
        branch_pkg::S_IDLE:  state_reg <= go ? branch_pkg::S_FETCH : branch_pkg::S_IDLE;
        branch_pkg::S_FETCH: state_reg <= branch_pkg::S_EXEC;
        branch_pkg::S_EXEC:  state_reg <= branch_pkg::S_IDLE;
        default:             state_reg <= branch_pkg::S_IDLE;
      endcase
    end
  end

  // compare writes four flags, plus aux on byte compares; the difference itself is dropped
  assign flags_next = (exec & (op_code == branch_pkg::OP_CMP))
                    ? {c_zero, c_sign, c_ovf, c_aux, c_carry}
                    : (wr_take & hit_flags) ? pwdata_i[4:0] : flags_reg;

  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      op_reg      <= 6'h00;
      next_pc_reg <= 24'h00_0000;
      operand_reg <= 24'h00_0000;
      acc_reg     <= 8'h00;
      data_pointer_reg    <= 16'h0000;
      bit_sel_reg <= 13'h0000;
      cmp_reg     <= 32'h0000_0000;
      flags_reg   <= `FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
      if (go)                 op_reg      <= pwdata_i[5:0];
      if (wr_take & hit_pc)   next_pc_reg <= pwdata_i[23:0];
      if (wr_take & hit_operand) operand_reg <= pwdata_i[23:0];
      if (wr_take & hit_accdp) begin
        acc_reg  <= pwdata_i[7:0];
        data_pointer_reg <= pwdata_i[23:8];
      end
      if (wr_take & hit_sel)  bit_sel_reg <= pwdata_i[12:0];
      if (wr_take & hit_cmp)  cmp_reg     <= pwdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pc_load_o      <= 1'b0;
      pc_target_o    <= 24'h00_0000;
      branch_taken_o <= 1'b0;
      loc_err_reg    <= 1'b0;
      block_err_reg  <= 1'b0;
      bit_val_reg    <= 1'b0;
    end else begin
      pc_load_o <= exec & taken_calc;
      if (exec) begin
        pc_target_o    <= taken_calc ? target_calc : next_pc_reg;
        branch_taken_o <= taken_calc;
        loc_err_reg    <= is_bit_op & ~loc_ok;
        block_err_reg  <= block_err;
        bit_val_reg    <= bit_now;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_sync_reg);

  wire [23:0] next_pc_keep = next_pc_reg;
  wire        cmp_equal    = wide ? (cmp_a == cmp_b) : (cmp_a[7:0] == cmp_b[7:0]);

  a_legacy_ram_map: assert property ((state_reg == branch_pkg::S_FETCH) && is_num && !sel_loc[7]
      |-> (byte_loc >= 8'h20) && (byte_loc <= 8'h2F) && (byte_loc[3:0] == sel_loc[6:3]))
    else $error("legacy numeric bit address left RAM bytes");
  a_legacy_sfr_map: assert property ((state_reg == branch_pkg::S_FETCH) && is_num && sel_loc[7]
      |-> (byte_loc[2:0] == 3'h0) && (byte_loc[7:3] == sel_loc[7:3]))
    else $error("legacy numeric bit address picked wrong SFR row");
  a_legacy_range: assert property (exec && is_bit_op && (sel_mode == `MODE_LEG_LOC)
      && (sel_loc >= 8'h30) && (sel_loc <= 8'h7F) |=> loc_err_reg)
    else $error("legacy location above 2FH was accepted");
  a_ext_range: assert property (exec && is_bit_op && (sel_mode == `MODE_EXT_LOC)
      && (sel_loc >= 8'h20) |=> !loc_err_reg)
    else $error("extended location wrongly refused");
  a_rel_target: assert property (exec && (op_code == branch_pkg::OP_REL)
      |=> pc_load_o && (pc_target_o == $past(next_pc_keep) + $past(rel_sext)))
    else $error("relative target wrong");
  a_eleven_keep: assert property (exec && (op_code == branch_pkg::OP_ABS11)
      |=> ((pc_target_o ^ $past(next_pc_keep)) & 24'hFF_F800) == 24'h00_0000)
    else $error("eleven-bit target changed upper bits");
  a_sixteen_keep: assert property (exec && ((op_code == branch_pkg::OP_LONG16)
      || (op_code == branch_pkg::OP_WORD_IND))
      |=> (((pc_target_o ^ $past(next_pc_keep)) & 24'hFF_0000) == 24'h00_0000)
       && (((pc_target_o ^ $past(operand_reg)) & 24'h00_FFFF) == 24'h00_0000))
    else $error("sixteen-bit target wrong");
  a_full_target: assert property (exec && (op_code == branch_pkg::OP_EXT24)
      |=> pc_target_o == $past(operand_reg))
    else $error("twentyfour-bit target wrong");
  a_acc_data_pointer: assert property (exec && (op_code == branch_pkg::OP_ACC_DATA_POINTER)
      |=> pc_target_o[23:16] == 8'hFF)
    else $error("data pointer jump left region FF");
  a_jbc_clear: assert property (exec && (op_code == branch_pkg::OP_JBC) && bit_now && loc_ok
      && !block_err |-> store_we && !store_wd[bit_pos] ##1 branch_taken_o)
    else $error("jump-and-clear did not clear or jump");
  a_block_limit: assert property (exec && block_err |=> !branch_taken_o && !pc_load_o)
    else $error("conditional jump left 256-byte block");
  a_cmp_zero: assert property (exec && (op_code == branch_pkg::OP_CMP)
      |=> flags_reg[`FLAG_ZERO] == $past(cmp_equal) && !pc_load_o)
    else $error("compare zero flag wrong");
  a_unsigned_above: assert property (exec && (op_code == branch_pkg::OP_JG) && !f_cy && !f_z
      && !block_err |=> branch_taken_o)
    else $error("unsigned above not taken");
  a_signed_less: assert property (exec && (op_code == branch_pkg::OP_JSL) && !f_lt
      |=> !branch_taken_o)
    else $error("signed less taken with sign equal to overflow");

  c_jbc_taken: cover property (exec && (op_code == branch_pkg::OP_JBC) ##1 branch_taken_o);
  c_compare:   cover property (exec && (op_code == branch_pkg::OP_CMP));
  c_signed:    cover property (exec && (op_code == branch_pkg::OP_JUMP_SIGNED_GREATER_OR_SAME) ##1 pc_load_o);

endmodule : branch_unit

// ---- logic/branch_defs.svh ----
// register offsets, field positions, reset values and encodings of the branch unit
// assumes a 32-bit APB slave with byte addresses and 8 address bits
`ifndef BRANCH_DEFS_SVH
`define BRANCH_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADDR_OP       8'h00
`define ADDR_NEXT_PC  8'h04
`define ADDR_OPERAND  8'h08
`define ADDR_ACC_DATA_POINTER 8'h0C
`define ADDR_BIT_SEL  8'h10
`define ADDR_FLAGS    8'h14
`define ADDR_CMP      8'h18
`define ADDR_RESULT   8'h1C

// ****************************************************************
// fields
// ****************************************************************
`define OP_WIDE_BIT   5
`define SEL_MODE_LSB  11
`define FLAG_CARRY    0
`define FLAG_AUX      1
`define FLAG_OVF      2
`define FLAG_SIGN     3
`define FLAG_ZERO     4
`define RES_TAKEN     24
`define RES_LOC_ERR   25
`define RES_BLK_ERR   26
`define RES_BIT_VAL   27
`define RES_BUSY      31

// ****************************************************************
// reset values and address limits
// ****************************************************************
`define FLAGS_RESET   5'h00
`define LOC_RAM_LO    8'h20
`define LOC_RAM_HI    8'h7F
`define LOC_LEGACY_HI 8'h2F
`define REGION_CODE   8'hFF

// ****************************************************************
// bit selection modes and operation codes
// ****************************************************************
`define MODE_EXT_LOC  2'h0
`define MODE_LEG_NUM  2'h1
`define MODE_LEG_LOC  2'h2
`define OPC_REL       5'h00
`define OPC_ABS11     5'h01
`define OPC_LONG16    5'h02
`define OPC_EXT24     5'h03
`define OPC_WORD_IND  5'h04
`define OPC_ACC_DATA_POINTER  5'h05
`define OPC_JB        5'h06
`define OPC_JNB       5'h07
`define OPC_JBC       5'h08
`define OPC_SETB      5'h09
`define OPC_CLRB      5'h0A
`define OPC_CMP       5'h0B
`define OPC_JE        5'h0C
`define OPC_JNE       5'h0D
`define OPC_JG        5'h0E
`define OPC_JL        5'h0F
`define OPC_JGE       5'h10
`define OPC_JLE       5'h11
`define OPC_JSG       5'h12
`define OPC_JSL       5'h13
`define OPC_JUMP_SIGNED_GREATER_OR_SAME      5'h14
`define OPC_JUMP_SIGNED_LESSER_OR_SAME      5'h15

`endif

// ---- logic/branch_pkg.sv ----
// types shared by the branch and bit addressing unit
// assumes branch_defs.svh is on the include path
`include "branch_defs.svh"

package branch_pkg;

  typedef enum logic [4:0] {
    OP_REL       = `OPC_REL,
    OP_ABS11     = `OPC_ABS11,
    OP_LONG16    = `OPC_LONG16,
    OP_EXT24     = `OPC_EXT24,
    OP_WORD_IND  = `OPC_WORD_IND,
    OP_ACC_DATA_POINTER  = `OPC_ACC_DATA_POINTER,
    OP_JB        = `OPC_JB,
    OP_JNB       = `OPC_JNB,
    OP_JBC       = `OPC_JBC,
    OP_SETB      = `OPC_SETB,
    OP_CLRB      = `OPC_CLRB,
    OP_CMP       = `OPC_CMP,
    OP_JE        = `OPC_JE,
    OP_JNE       = `OPC_JNE,
    OP_JG        = `OPC_JG,
    OP_JL        = `OPC_JL,
    OP_JGE       = `OPC_JGE,
    OP_JLE       = `OPC_JLE,
    OP_JSG       = `OPC_JSG,
    OP_JSL       = `OPC_JSL,
    OP_JUMP_SIGNED_GREATER_OR_SAME      = `OPC_JUMP_SIGNED_GREATER_OR_SAME,
    OP_JUMP_SIGNED_LESSER_OR_SAME      = `OPC_JUMP_SIGNED_LESSER_OR_SAME
  } op_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_FETCH,
    S_EXEC
  } state_t;

endpackage : branch_pkg

// ---- logic/bit_byte_store.sv ----
// byte store for bit-addressable RAM (20H-7FH) and SFR space (80H-FFH)
// assumes one access per cycle; read data registered, write wins the array
`timescale 1ns/1ns

module bit_byte_store (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] rd_data_o
);

  logic [7:0] mem [0:255];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem[addr_i];
    end
  end

endmodule : bit_byte_store

// ---- verification/testbench.sv ----
// self-checking bench for the branch target and bit operand unit
// assumes branch_defs.svh on the include path; APB master driven from here
`timescale 1ns/1ns
`include "branch_defs.svh"

module testbench;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, r;
  logic        pready_o, pslverr_o, pc_load_o, branch_taken_o, err, t;
  logic [23:0] pc_target_o, n, o, e;
  logic [4:0]  c, f;
  logic [15:0] a, b;
  logic [16:0] d;
  logic [6:0]  q;
  logic        w, pl;
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  branch_unit i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .branch_taken_o(branch_taken_o));

  // ****************************************************************
  // bus tasks and expectations
  // ****************************************************************
  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= dt;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) @(posedge clk_sys_i);
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // op write, result settles two edges later, then read back
  task run(input logic [5:0] op);
    apb(1'b1, `ADDR_OP, {26'h0, op});
    repeat (3) @(posedge clk_sys_i);
    pl = pc_load_o;
    apb(1'b0, `ADDR_RESULT, 32'h0);
  endtask : run

  task jmp(input logic [4:0] op, input logic tk, input logic [23:0] x);
    run({1'b0, op});
    chk(32'(r[24:0]), 32'({tk, x}));
    chk(32'({branch_taken_o, pc_target_o}), 32'({tk, x}));
    chk(32'({pl, pc_load_o}), 32'({tk, 1'b0}));
  endtask : jmp

  task bs(input logic [1:0] m, input logic [2:0] p, input logic [7:0] by);
    apb(1'b1, `ADDR_BIT_SEL, {19'h0, m, p, by});
  endtask : bs

  function automatic logic [23:0] tgt(input logic [4:0] op, input logic [23:0] nx, v);
    case (op)
      `OPC_REL:      tgt = nx + {{16{v[7]}}, v[7:0]};
      `OPC_ABS11:    tgt = {nx[23:11], v[10:0]};
      `OPC_EXT24:    tgt = v;
      `OPC_ACC_DATA_POINTER: tgt = {8'hFF, v[23:8] + {8'h00, v[7:0]}};
      default:       tgt = {nx[23:16], v[15:0]};
    endcase
  endfunction : tgt

  function automatic logic cond(input logic [4:0] op, input logic [4:0] fl);
    logic lt;
    lt = fl[3] ^ fl[2];
    case (op)
      `OPC_JE:   cond = fl[4];
      `OPC_JNE:  cond = !fl[4];
      `OPC_JG:   cond = !fl[0] && !fl[4];
      `OPC_JL:   cond = fl[0];
      `OPC_JGE:  cond = !fl[0];
      `OPC_JLE:  cond = fl[0] || fl[4];
      `OPC_JSG:  cond = !fl[4] && !lt;
      `OPC_JSL:  cond = lt;
      `OPC_JUMP_SIGNED_GREATER_OR_SAME: cond = !lt;
      default:   cond = fl[4] || lt;
    endcase
  endfunction : cond

  task results;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    results();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    void'($urandom(32'h1C642CE7));
    repeat (4) @(posedge clk_sys_i);
    chk(32'({pready_o, pc_load_o, branch_taken_o}), 32'h0);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    apb(1'b0, 8'h20, 32'h0);
    chk({err, r[30:0]}, {1'b1, 31'h0});
    chk(32'(pready_o), 32'h1);
    for (int k = 0; k < 24; k++) begin
      c = 5'(k % 6);
      n = (k < 6) ? 24'h12FFFF : 24'($urandom);
      o = (k < 6) ? 24'hFFFF80 : 24'($urandom);
      apb(1'b1, `ADDR_NEXT_PC, {8'h0, n});
      apb(1'b1, `ADDR_OPERAND, {8'h0, o});
      apb(1'b1, `ADDR_ACC_DATA_POINTER, {8'h0, o});
      jmp(c, 1'b1, tgt(c, n, o));
    end
    $display("direct and relative targets done");
    for (int k = 0; k < 40; k++) begin
      c = 5'(`OPC_JE + k % 10);
      f = 5'($urandom);
      n = 24'($urandom);
      o = 24'($urandom);
      apb(1'b1, `ADDR_FLAGS, {27'h0, f});
      apb(1'b1, `ADDR_NEXT_PC, {8'h0, n});
      apb(1'b1, `ADDR_OPERAND, {8'h0, o});
      e = tgt(`OPC_REL, n, o);
      t = cond(c, f) && e[23:8] == n[23:8];
      jmp(c, t, t ? e : n);
    end
    $display("flag conditional jumps done");
    apb(1'b1, `ADDR_OPERAND, 32'h0);
    for (int k = 0; k < 8; k++) begin
      a = 16'($urandom);
      b = (k == 0) ? a : (k == 1) ? 16'h8000 : 16'($urandom);
      w = k[0];
      d = w ? {1'b0, a} - {1'b0, b} : {8'h00, {1'b0, a[7:0]} - {1'b0, b[7:0]}};
      t = w ? ($signed(a) < $signed(b)) : ($signed(a[7:0]) < $signed(b[7:0]));
      apb(1'b1, `ADDR_CMP, {b, a});
      run({w, `OPC_CMP});
      apb(1'b0, `ADDR_FLAGS, 32'h0);
      chk(32'(r[4:0] & {3'h7, ~w, 1'b1}), 32'({w ? d[15:0] == 16'h0 : d[7:0] == 8'h00,
        w ? d[15] : d[7],
        w ? (a[15] ^ b[15]) & (a[15] ^ d[15]) : (a[7] ^ b[7]) & (a[7] ^ d[7]),
        ~w & (a[3:0] < b[3:0]), w ? d[16] : d[8]}));
      jmp(`OPC_JSL, t, n);
    end
    $display("compare done");
    n = 24'h001000;
    apb(1'b1, `ADDR_NEXT_PC, {8'h0, n});
    apb(1'b1, `ADDR_OPERAND, 32'h10);
    for (int k = 0; k < 6; k++) begin
      q = 7'($urandom);
      bs(2'h0, q[2:0], 8'h20 + {4'h0, q[6:3]});
      run({1'b0, `OPC_CLRB});
      bs(2'h1, 3'h0, {1'b0, q});
      jmp(`OPC_JNB, 1'b1, n + 24'h10);
      run({1'b0, `OPC_SETB});
      bs(2'h2, q[2:0], 8'h20 + {4'h0, q[6:3]});
      jmp(`OPC_JB, 1'b1, n + 24'h10);
      jmp(`OPC_JBC, 1'b1, n + 24'h10);
      jmp(`OPC_JB, 1'b0, n);
      bs(2'h0, q[2:0], 8'h88);
      run({1'b0, `OPC_SETB});
      bs(2'h1, 3'h0, {5'h11, q[2:0]});
      jmp(`OPC_JB, 1'b1, n + 24'h10);
      bs(2'h0, q[2:0], 8'h8B);
      run({1'b0, `OPC_SETB});
      jmp(`OPC_JB, 1'b1, n + 24'h10);
    end
    for (int k = 0; k < 4; k++) begin
      bs((k == 0) ? 2'h0 : (k == 3) ? 2'h3 : 2'h2, 3'h3, (k == 0) ? 8'h1F : (k == 1) ? 8'h89
        : (k == 2) ? 8'h30 : 8'h20);
      jmp(`OPC_JB, 1'b0, n);
      chk(32'(r[25]), 32'h1);
    end
    $display("bit addressing done");
    results();
  end
endmodule : testbench
